// >>> hdl/adc_serial_readout_chain.sv
// Functional notes
// - Tag bits follow result LSB when enabled
// - Tag is plain binary channel index
// - Chain enable makes status pin chain input
// - Chain input emerges after 16/24 SCLKs
// - First word after frame start is own result
// - Later words are upstream data in order
// - New frame restarts with own result, except the first after reset
// - No strobe: old result, chain still passes
// - Tag without chain: tag then zeros
// - Chain with tag: 24 bits, five zeros
// - Power-on, soft and pin reset restore defaults
// - Soft reset bit written 0, reads 1
// - External reset pin low resets device
// - Chain bit 0 selects chain input
// - Tag bit 1 enables trailing tag
// - First frame after reset sends all ones
`include "adc_readout_map.svh"
`timescale 1ns/1ns

module adc_serial_readout_chain
#(
    parameter int RESET_WAIT_NS = `ADC_RESET_WAIT_NS
)
(
    // Clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic reset_pin_n,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    input wire logic frame_select_n,
    input wire logic sclk,
    output logic sdo,
    output logic sdo_oe,
    // Shared pin: chain data input or conversion-done output
    input wire logic pin10_in,
    output logic pin10_out,
    output logic pin10_oe,
    // Sampling strobe pin
    input wire logic sample_end_strobe_n,
    // Converter core
    input wire logic conv_done,
    input wire logic [15:0] conv_data,
    output logic conv_start
);

    localparam int WAIT_CYC_I = (RESET_WAIT_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS;
    localparam logic [15:0] WAIT_CYC = WAIT_CYC_I[15:0];

    ////////////////////////////////////////////////////////////////////////////
    // Reset: power-on and pin reset assert at once, release on the clock.

    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge pclk or negedge presetn or negedge reset_pin_n)
    begin
        if (!presetn || !reset_pin_n)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end

    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [1:0] sclk_s1_ff, fs_s1_ff, cin_s1_ff, stb_s1_ff;
    logic sclk_d_ff, fs_d_ff, stb_d_ff;
    logic sclk_fall, fs_fall, fs_rise, stb_fall;

    always_ff @(posedge pclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_s1_ff <= 2'h0;
            fs_s1_ff <= 2'h3;
            cin_s1_ff <= 2'h0;
            stb_s1_ff <= 2'h3;
            sclk_d_ff <= 1'h0;
            fs_d_ff <= 1'h1;
            stb_d_ff <= 1'h1;
        end
        else
        begin
            sclk_s1_ff <= {sclk_s1_ff[0], sclk};
            fs_s1_ff <= {fs_s1_ff[0], frame_select_n};
            cin_s1_ff <= {cin_s1_ff[0], pin10_in};
            stb_s1_ff <= {stb_s1_ff[0], sample_end_strobe_n};
            sclk_d_ff <= sclk_s1_ff[1];
            fs_d_ff <= fs_s1_ff[1];
            stb_d_ff <= stb_s1_ff[1];
        end
    end

    assign sclk_fall = sclk_d_ff && !sclk_s1_ff[1];
    assign fs_fall = fs_d_ff && !fs_s1_ff[1];
    assign fs_rise = !fs_d_ff && fs_s1_ff[1];
    assign stb_fall = stb_d_ff && !stb_s1_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // APB registers and soft reset.

    adc_readout_pkg::cfg_t cfg_ff, nxt_cfg;
    logic [2:0] chan_sel_ff, nxt_chan_sel;
    logic sreset_ff, nxt_sreset;
    logic [15:0] wait_cnt_ff, nxt_wait_cnt;
    logic [31:0] prdata_ff, nxt_prdata;
    logic acc, wr_cfg, rd_val_ok;
    logic [31:0] rd_val;

    // Status bits supplied by the link and sampling sections below.
    logic ready_flag_ff;
    adc_readout_pkg::link_state_t state_ff;
    adc_readout_pkg::result_t result_ff;

    assign acc = psel && penable;
    assign wr_cfg = acc && pwrite && (paddr == `ADC_CFG_OFF);

    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_val_ok = 1'h1;
        if (paddr == `ADC_CFG_OFF)
        begin
            rd_val[`ADC_CHAIN_BIT] = cfg_ff.chain_enable_bit;
            rd_val[`ADC_TAG_BIT] = cfg_ff.tag_enable_bit;
            rd_val[`ADC_SOFT_BIT] = 1'h1;
        end
        else if (paddr == `ADC_STATUS_OFF)
        begin
            rd_val[`ADC_ST_READY_BIT] = (wait_cnt_ff == 16'h0000);
            rd_val[`ADC_ST_RESULT_BIT] = ready_flag_ff;
            rd_val[`ADC_ST_FRAME_BIT] = (state_ff == adc_readout_pkg::LINK_FRAME);
            rd_val[`ADC_ST_TAG_LSB +: `ADC_TAG_W] = result_ff.tag;
        end
        else if (paddr == `ADC_CHAN_OFF)
            rd_val[`ADC_TAG_W-1:0] = chan_sel_ff;
        else
            rd_val_ok = 1'h0;
    end

    always_comb
    begin
        nxt_cfg = cfg_ff;
        nxt_chan_sel = chan_sel_ff;
        nxt_sreset = 1'h0;
        nxt_prdata = prdata_ff;
        nxt_wait_cnt = (wait_cnt_ff != 16'h0000) ? wait_cnt_ff - 16'h0001 : wait_cnt_ff;
        if (psel && !penable && !pwrite)
            nxt_prdata = rd_val;
        if (sreset_ff)
        begin
            nxt_cfg.chain_enable_bit = `ADC_CHAIN_RST;
            nxt_cfg.tag_enable_bit = `ADC_TAG_RST;
            nxt_chan_sel = 3'h0;
            nxt_wait_cnt = WAIT_CYC;
        end
        else if (wr_cfg && !pwdata[`ADC_SOFT_BIT])
            nxt_sreset = 1'h1;
        else if (wr_cfg)
        begin
            nxt_cfg.chain_enable_bit = pwdata[`ADC_CHAIN_BIT];
            nxt_cfg.tag_enable_bit = pwdata[`ADC_TAG_BIT];
        end
        else if (acc && pwrite && (paddr == `ADC_CHAN_OFF))
            nxt_chan_sel = pwdata[`ADC_TAG_W-1:0];
    end

    always_ff @(posedge pclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_ff <= '{chain_enable_bit: `ADC_CHAIN_RST, tag_enable_bit: `ADC_TAG_RST};
            chan_sel_ff <= 3'h0;
            sreset_ff <= 1'h0;
            wait_cnt_ff <= WAIT_CYC;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
            chan_sel_ff <= nxt_chan_sel;
            sreset_ff <= nxt_sreset;
            wait_cnt_ff <= nxt_wait_cnt;
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'h1;
    assign pslverr = acc && !rd_val_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Sampling and result capture.

    logic [2:0] samp_chan_ff, nxt_samp_chan;
    logic conv_start_ff, nxt_conv_start;
    adc_readout_pkg::result_t nxt_result;

    always_comb
    begin
        nxt_samp_chan = samp_chan_ff;
        nxt_result = result_ff;
        nxt_conv_start = 1'h0;
        if (sreset_ff)
        begin
            nxt_samp_chan = 3'h0;
            nxt_result = '0;
        end
        else
        begin
            if (stb_fall)
            begin
                nxt_samp_chan = chan_sel_ff;
                nxt_conv_start = 1'h1;
            end
            if (conv_done)
            begin
                nxt_result.data = conv_data;
                nxt_result.tag = samp_chan_ff;
            end
        end
    end

    always_ff @(posedge pclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            samp_chan_ff <= 3'h0;
            result_ff <= '0;
            conv_start_ff <= 1'h0;
        end
        else
        begin
            samp_chan_ff <= nxt_samp_chan;
            result_ff <= nxt_result;
            conv_start_ff <= nxt_conv_start;
        end
    end

    assign conv_start = conv_start_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Output shift register and link.

    logic [`ADC_SHIFT_W-1:0] shreg_ff, nxt_shreg;
    logic first_frame_ff, nxt_first_frame, nxt_ready_flag;
    adc_readout_pkg::link_state_t nxt_state;
    logic chain_mode;

    assign chain_mode = !cfg_ff.chain_enable_bit;

    always_comb
    begin
        nxt_shreg = shreg_ff;
        nxt_state = state_ff;
        nxt_first_frame = first_frame_ff;
        nxt_ready_flag = ready_flag_ff;
        if (sreset_ff)
        begin
            nxt_shreg = '0;
            nxt_state = adc_readout_pkg::LINK_IDLE;
            nxt_first_frame = 1'h1;
            nxt_ready_flag = 1'h0;
        end
        else
        begin
            case (state_ff)
                adc_readout_pkg::LINK_IDLE:
                begin
                    if (fs_fall)
                    begin
                        nxt_state = adc_readout_pkg::LINK_FRAME;
                        nxt_ready_flag = 1'h0;
                        if (first_frame_ff)
                            nxt_shreg = '1;
                        else if (cfg_ff.tag_enable_bit)
                            nxt_shreg = {result_ff.data, result_ff.tag, 5'h00};
                        else
                            nxt_shreg = {result_ff.data, 8'h00};
                    end
                end
                adc_readout_pkg::LINK_FRAME:
                begin
                    if (fs_rise)
                    begin
                        nxt_state = adc_readout_pkg::LINK_IDLE;
                        nxt_first_frame = 1'h0;
                    end
                    else if (sclk_fall)
                    begin
                        nxt_shreg = {shreg_ff[`ADC_SHIFT_W-2:0], 1'h0};
                        if (chain_mode && cfg_ff.tag_enable_bit)
                            nxt_shreg[0] = cin_s1_ff[1];
                        else if (chain_mode)
                            nxt_shreg[`ADC_NOTAG_INS] = cin_s1_ff[1];
                    end
                end
                default:
                    nxt_state = adc_readout_pkg::LINK_IDLE;
            endcase
            if (conv_done)
                nxt_ready_flag = 1'h1;
        end
    end

    always_ff @(posedge pclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shreg_ff <= '0;
            state_ff <= adc_readout_pkg::LINK_IDLE;
            first_frame_ff <= 1'h1;
            ready_flag_ff <= 1'h0;
        end
        else
        begin
            shreg_ff <= nxt_shreg;
            state_ff <= nxt_state;
            first_frame_ff <= nxt_first_frame;
            ready_flag_ff <= nxt_ready_flag;
        end
    end

    assign sdo = shreg_ff[`ADC_SHIFT_W-1];
    assign sdo_oe = (state_ff == adc_readout_pkg::LINK_FRAME);
    assign pin10_out = ready_flag_ff;
    assign pin10_oe = cfg_ff.chain_enable_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!rst_n);

    logic load_ev;
    assign load_ev = (state_ff == adc_readout_pkg::LINK_IDLE) && fs_fall && !sreset_ff;

    sequence soft_write_s;
        wr_cfg && !pwdata[`ADC_SOFT_BIT] && !sreset_ff;
    endsequence

    sequence defaults_s;
        sreset_ff ##1 (cfg_ff.chain_enable_bit && !cfg_ff.tag_enable_bit && first_frame_ff);
    endsequence

    a_soft_reset_default: assert property (soft_write_s |=> defaults_s)
        else $error("soft reset did not restore defaults");
    a_first_frame_ones: assert property (load_ev && first_frame_ff |=> shreg_ff == '1)
        else $error("first frame after reset not all ones");
    a_own_result_first: assert property (load_ev && !first_frame_ff
        |=> shreg_ff[`ADC_SHIFT_W-1 -: `ADC_RESULT_W] == $past(result_ff.data))
        else $error("frame did not start with own result");
    a_tag_after_lsb: assert property (load_ev && !first_frame_ff && cfg_ff.tag_enable_bit
        |=> shreg_ff[7:0] == {$past(result_ff.tag), 5'h00})
        else $error("tag bits misplaced after result");
    a_no_tag_zero: assert property (load_ev && !first_frame_ff && !cfg_ff.tag_enable_bit
        |=> shreg_ff[7:0] == 8'h00)
        else $error("trailing bits not zero with tag off");
    a_tag_is_sampled: assert property (conv_done && !sreset_ff
        |=> result_ff.tag == $past(samp_chan_ff))
        else $error("tag does not match sampled channel");
    a_chain_insert_notag: assert property (state_ff == adc_readout_pkg::LINK_FRAME && sclk_fall
        && !fs_rise && chain_mode && !cfg_ff.tag_enable_bit && !sreset_ff
        |=> shreg_ff[`ADC_NOTAG_INS] == $past(cin_s1_ff[1]))
        else $error("chain bit not inserted at 16 bit depth");
    a_chain_insert_tag: assert property (state_ff == adc_readout_pkg::LINK_FRAME && sclk_fall
        && !fs_rise && chain_mode && cfg_ff.tag_enable_bit && !sreset_ff
        |=> shreg_ff[0] == $past(cin_s1_ff[1]))
        else $error("chain bit not inserted at 24 bit depth");
    a_result_hold: assert property (!conv_done && !sreset_ff |=> $stable(result_ff))
        else $error("result changed without conversion");
    a_pin_direction: assert property (pin10_oe == !chain_mode)
        else $error("shared pin direction wrong");

endmodule : adc_serial_readout_chain

// >>> pkg/adc_readout_map.svh
`ifndef ADC_READOUT_MAP_SVH
`define ADC_READOUT_MAP_SVH

// Register byte offsets on the APB bus.
`define ADC_CFG_OFF 12'h000
`define ADC_STATUS_OFF 12'h004
`define ADC_CHAN_OFF 12'h008

// Configuration register field positions.
`define ADC_CHAIN_BIT 5
`define ADC_TAG_BIT 1
`define ADC_SOFT_BIT 0

// Configuration reset values: pin used as status output, tags off.
`define ADC_CHAIN_RST 1'h1
`define ADC_TAG_RST 1'h0

// Status register field positions.
`define ADC_ST_READY_BIT 0
`define ADC_ST_RESULT_BIT 1
`define ADC_ST_FRAME_BIT 2
`define ADC_ST_TAG_LSB 4

// Output word layout.
`define ADC_SHIFT_W 24
`define ADC_RESULT_W 16
`define ADC_TAG_W 3
`define ADC_PAD_W 5
`define ADC_NOTAG_INS 8

// Timing.
`define ADC_CLK_PERIOD_NS 100
`define ADC_RESET_WAIT_NS 2000

`endif

// >>> pkg/adc_readout_pkg.sv
package adc_readout_pkg;

    typedef struct packed {
        logic chain_enable_bit;
        logic tag_enable_bit;
    } cfg_t;

    typedef struct packed {
        logic [15:0] data;
        logic [2:0] tag;
    } result_t;

    typedef enum logic {
        LINK_IDLE,
        LINK_FRAME
    } link_state_t;

endpackage : adc_readout_pkg

// >>> verification/serial_host_model.sv
`timescale 1ns/1ns

module serial_host_model
(
    // Clock
    input wire logic pclk,
    // Serial link
    input wire logic sdo,
    output logic frame_select_n,
    output logic sclk,
    // Upstream converter output into the chain input
    output logic chain_data_in
);

    initial
    begin
        frame_select_n = 1'b1;
        sclk = 1'b0;
        chain_data_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////

    // The upstream output is released between frames, so it toggles to expose stale data.
    always @(posedge pclk)
    begin
        if (frame_select_n)
        begin
            chain_data_in <= ~chain_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // SCLK idles low and only runs inside a frame; data is taken late in the high phase.
    task automatic frame(input int n, input logic [63:0] up, output logic [63:0] got);
        got = 64'h0;
        @(posedge pclk);
        frame_select_n <= 1'b0;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < n; i++)
        begin
            sclk <= 1'b1;
            chain_data_in <= up[63 - i];
            repeat (4) @(posedge pclk);
            got = {got[62:0], sdo};
            sclk <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        frame_select_n <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : frame

endmodule : serial_host_model

// >>> verification/testbench.sv
`timescale 1ns/1ns
`include "adc_readout_map.svh"

module testbench;

    logic pclk, presetn, reset_pin_n, psel, penable, pwrite, strobe_n, conv_done, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [15:0] conv_data;
    logic [63:0] got;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, sdo, sdo_oe, pin10_out, pin10_oe, conv_start, fs_n, sclk, din;
    int error_cnt, num_checks, cyc;

    adc_serial_readout_chain #(.RESET_WAIT_NS(200)) adc_serial_readout_chain_i (
        .pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_select_n(fs_n), .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe),
        .pin10_in(din), .pin10_out(pin10_out), .pin10_oe(pin10_oe),
        .sample_end_strobe_n(strobe_n), .conv_done(conv_done), .conv_data(conv_data),
        .conv_start(conv_start));

    serial_host_model serial_host_model_i (.pclk(pclk), .sdo(sdo), .frame_select_n(fs_n),
        .sclk(sclk), .chain_data_in(din));

    always #50 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////////

    task give_verdict;
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_reg

    task chk_ser(input logic [63:0] g, input logic [63:0] e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk_ser

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Waits the settling time after a reset, then checks the default mode.
    task check_defaults;
        repeat (20) @(posedge pclk);
        rd = 32'h0;
        while (rd[0] !== 1'b1) apb(1'b0, `ADC_STATUS_OFF, 32'h0, rd, err);
        apb(1'b0, `ADC_CFG_OFF, 32'h0, rd, err);
        chk_reg(rd & 32'h23, 32'h21);
        serial_host_model_i.frame(16, 64'h0, got);
        chk_ser(got, 64'hFFFF);
    endtask : check_defaults

    // Acts as the converter core; the channel is changed after sampling.
    task convert(input logic [2:0] ch, input logic [15:0] d);
        apb(1'b1, `ADC_CHAN_OFF, {29'h0, ch}, rd, err);
        @(posedge pclk);
        strobe_n <= 1'b0;
        do @(posedge pclk); while (conv_start !== 1'b1);
        conv_done <= 1'b1;
        conv_data <= d;
        strobe_n <= 1'b1;
        @(posedge pclk);
        conv_done <= 1'b0;
        apb(1'b1, `ADC_CHAN_OFF, {29'h0, ~ch}, rd, err);
    endtask : convert

    ////////////////////////////////////////////////////////////////////////////////

    initial
    begin
        pclk = 1'b0;
        cyc = 0;
        error_cnt = 0;
        num_checks = 0;
        presetn = 1'b0;
        reset_pin_n = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        strobe_n = 1'b1;
        conv_done = 1'b0;
        conv_data = 16'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check_defaults();
        apb(1'b1, 12'h00C, 32'hFFFFFFFF, rd, err);
        chk_reg({31'h0, err}, 32'h1);
        apb(1'b0, 12'h00C, 32'h0, rd, err);
        chk_reg({rd[30:0], err}, 32'h1);
        apb(1'b1, `ADC_CFG_OFF, 32'h23, rd, err);
        @(posedge pclk);
        chk_reg({31'h0, pin10_oe}, 32'h1);
        for (int ch = 0; ch < 8; ch++)
        begin
            convert(ch[2:0], {ch[3:0], 12'hA5C});
            chk_reg({30'h0, pin10_out, sdo_oe}, 32'h2);
            serial_host_model_i.frame(24, 64'h0, got);
            chk_ser(got, {40'h0, ch[3:0], 12'hA5C, ch[2:0], 5'h0});
        end
        serial_host_model_i.frame(19, 64'h0, got);
        chk_ser(got, {45'h0, 16'h7A5C, 3'h7});
        apb(1'b1, `ADC_CFG_OFF, 32'h01, rd, err);
        @(posedge pclk);
        chk_reg({31'h0, pin10_oe}, 32'h0);
        convert(3'h2, 16'hC3A5);
        serial_host_model_i.frame(32, {16'h5A0F, 48'h0}, got);
        chk_ser(got, {32'h0, 16'hC3A5, 16'h5A0F});
        serial_host_model_i.frame(48, {32'h11112222, 32'h0}, got);
        chk_ser(got, {16'h0, 16'hC3A5, 32'h11112222});
        repeat (2)
        begin
            serial_host_model_i.frame(16, {16'h5A0F, 48'h0}, got);
            chk_ser(got, {48'h0, 16'hC3A5});
        end
        apb(1'b1, `ADC_CFG_OFF, 32'h03, rd, err);
        serial_host_model_i.frame(48, {16'h7E81, 8'hC0, 40'h0}, got);
        chk_ser(got, {16'h0, 16'hC3A5, 8'h40, 16'h7E81, 8'hC0});
        apb(1'b1, `ADC_CFG_OFF, 32'h22, rd, err);
        check_defaults();
        apb(1'b1, `ADC_CFG_OFF, 32'h03, rd, err);
        @(posedge pclk);
        reset_pin_n <= 1'b0;
        @(posedge pclk);
        reset_pin_n <= 1'b1;
        check_defaults();
        give_verdict();
    end

endmodule : testbench
